// File: bench/ident_bank_properties.sv
`default_nettype none
module ident_bank_properties (
  input wire logic        clk,
  input wire logic        srst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pready,
  input wire logic [31:0] prdata,
  input wire logic        rx_timeout_event,
  input wire logic        rx_overrun_event,
  input wire logic        rx_timeout_flag,
  input wire logic        rx_overrun_flag
);
  // writes act on the edge that completes the access phase
  wire su = psel & ~penable;
  wire wc = psel & penable & pready & pwrite & (paddr == 12'h020);
  wire rq = su & ~pwrite;
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  //////////
  // a coinciding event wins, so it is excluded
  a_clr_timeout: assert property (wc & pwdata[1] & ~rx_timeout_event |=> !rx_timeout_flag)
    else $error("timeout kept");
  a_keep_timeout: assert property (wc & ~pwdata[1] & rx_timeout_flag |=> rx_timeout_flag)
    else $error("timeout lost");
  a_clr_overrun: assert property (wc & pwdata[0] & ~rx_overrun_event |=> !rx_overrun_flag)
    else $error("overrun kept");
  a_rsvd_zero: assert property (pready |-> prdata[31:8] == 24'h0)
    else $error("upper bits set");
  a_ident_four: assert property (rq & (paddr == 12'hfd0) |=> prdata == 32'h11)
    else $error("ident4 wrong");
  a_ident_three: assert property (rq & (paddr == 12'hfec) |=> prdata == 32'h04)
    else $error("ident3 wrong");
  a_cell_one: assert property (rq & (paddr == 12'hff4) |=> prdata == 32'h6b)
    else $error("cell1 wrong");
  a_clear_zero: assert property (rq & (paddr == 12'h020) |=> prdata == 32'h0)
    else $error("clear reads");
  cover property (wc & pwdata[1] & rx_timeout_flag);
  cover property (wc & ~pwdata[1] & rx_timeout_flag);
  cover property (rq & (paddr == 12'hff4));
endmodule
bind serial_port_ident_and_irq_clear ident_bank_properties ident_bank_properties_inst (.*);
`default_nettype wire

// File: bench/serial_port_ident_and_irq_clear_bench.sv
`default_nettype none
module serial_port_ident_and_irq_clear_bench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, er;
  logic        rx_timeout_event = 0, rx_overrun_event = 0, pready, pslverr;
  logic        rx_timeout_flag, rx_overrun_flag, irq;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  int          err_total = 0, cmp_count = 0, cyc = 0;
  logic [11:0] ad [10] = '{12'hfd0, 12'hfd4, 12'hfd8, 12'hfdc, 12'hfe0,
                           12'hfe4, 12'hfe8, 12'hfec, 12'hff0, 12'hff4};
  logic [7:0]  ex [10] = '{8'h11, 8'h62, 8'h73, 8'h48, 8'h5a,
                           8'h3c, 8'h27, 8'h04, 8'h9e, 8'h6b};
  `define chk(g, e) begin cmp_count++; if ((g) !== (e)) begin err_total++; \
    $display("unexpected %0t got %h exp %h", $time, g, e); end end
  always #50 clk = ~clk;
  serial_port_ident_and_irq_clear serial_port_ident_and_irq_clear_inst (.*);
  //////////
  task automatic complete_run;
    $display("compares %0d mismatches %0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // request held until pready is seen high at an edge
  task automatic xf(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    er = pslverr;
    psel <= 0;
    penable <= 0;
  endtask
  task automatic pulse(input logic [1:0] v);
    @(posedge clk) {rx_timeout_event, rx_overrun_event} <= v;
    @(posedge clk) {rx_timeout_event, rx_overrun_event} <= 2'h0;
    repeat (2) @(posedge clk);
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 2000) begin
      err_total++;
      complete_run();
    end
  end
  initial begin
    repeat (20) @(posedge clk);
    srst <= 0;
    for (int i = 0; i < 10; i++) begin
      xf(1, ad[i], 32'hffffffff);
      xf(0, ad[i], 0);
      `chk({er, rd}, {25'h0, ex[i]})
    end
    xf(0, 12'h100, 0);
    `chk({er, rd}, {1'b1, 32'h0})
    xf(1, 12'h028, 3);
    for (int b = 0; b < 2; b++) begin
      pulse(2'(1 << b));
      `chk({rx_timeout_flag, rx_overrun_flag, irq}, {2'(1 << b), 1'b1})
      xf(1, 12'h020, 32'(2 >> b));
      `chk({rx_timeout_flag, rx_overrun_flag}, 2'(1 << b))
      xf(1, 12'h020, 32'(1 << b));
      xf(0, 12'h020, 0);
      `chk({rx_timeout_flag, rx_overrun_flag, irq, rd}, 35'h0)
    end
    // masked event still latches but keeps irq low
    xf(1, 12'h028, 0);
    pulse(2'h2);
    xf(0, 12'h024, 0);
    `chk({irq, rd}, 33'h2)
    complete_run();
  end
endmodule
`default_nettype wire

// File: design/ident_consts.svh
`ifndef IDENT_CONSTS_SVH
`define IDENT_CONSTS_SVH

// register byte offsets
`define OFS_IRQ_CLEAR    12'h020
`define OFS_IRQ_STATUS   12'h024
`define OFS_IRQ_MASK     12'h028
`define OFS_IDENT4       12'hfd0
`define OFS_IDENT5       12'hfd4
`define OFS_IDENT6       12'hfd8
`define OFS_IDENT7       12'hfdc
`define OFS_IDENT0       12'hfe0
`define OFS_IDENT1       12'hfe4
`define OFS_IDENT2       12'hfe8
`define OFS_IDENT3       12'hfec
`define OFS_CELL0        12'hff0
`define OFS_CELL1        12'hff4

// field positions
`define BIT_RX_OVERRUN   0
`define BIT_RX_TIMEOUT   1
`define IRQ_BITS         2

// reset values
`define RST_IRQ          2'h0
`define RST_MASK         2'h0

// identity bytes, values arbitrary
`define IDENT_BYTE0      8'h5a
`define IDENT_BYTE1      8'h3c
`define IDENT_BYTE2      8'h27
`define IDENT_BYTE3      8'h04
`define IDENT_BYTE4      8'h11
`define IDENT_BYTE5      8'h62
`define IDENT_BYTE6      8'h73
`define IDENT_BYTE7      8'h48
`define CELL_BYTE0       8'h9e
`define CELL_BYTE1       8'h6b

`endif

// File: design/ident_pkg.sv
`default_nettype none
package ident_pkg;
  typedef enum logic [0:0] {
    APB_IDLE   = 1'b0,
    APB_ACCESS = 1'b1
  } apb_phase_t;
  typedef logic [7:0] ident_byte_t;
endpackage
`default_nettype wire

// File: design/ident_rom.sv
`default_nettype none
`include "ident_consts.svh"
module ident_rom (
  input  wire logic [11:0] addr,
  output logic             hit,
  output logic [7:0]       data
);
  // hard-wired, no storage: contents equal reset values
  always_comb begin
    hit  = 1'b1;
    data = 8'h00;
    case (addr)
      `OFS_IDENT4: data = `IDENT_BYTE4;
      `OFS_IDENT5: data = `IDENT_BYTE5;
      `OFS_IDENT6: data = `IDENT_BYTE6;
      `OFS_IDENT7: data = `IDENT_BYTE7;
      `OFS_IDENT0: data = `IDENT_BYTE0;
      `OFS_IDENT1: data = `IDENT_BYTE1;
      `OFS_IDENT2: data = `IDENT_BYTE2;
      `OFS_IDENT3: data = `IDENT_BYTE3;
      `OFS_CELL0:  data = `CELL_BYTE0;
      `OFS_CELL1:  data = `CELL_BYTE1;
      default:     hit  = 1'b0;
    endcase
  end
endmodule
`default_nettype wire

// File: design/serial_port_ident_and_irq_clear.sv
// Behaviour
// - writing 1 to a clear bit clears the rx time-out or rx overrun interrupt, 0 leaves it.
// - peripheral identity registers are read-only, byte in 7:0, bits 31:8 zero.
// - cell identity registers are hard-wired and read-only.
// - identity bytes four to seven sit at 0xfd0 to 0xfdc.
// - identity bytes zero to three sit at 0xfe0 to 0xfec.
// - cell identity bytes zero and one sit at 0xff0 and 0xff4.
// - the interrupt clear register sits at 0x020.
//
// Chosen here: the APB slave port.
`default_nettype none
`include "ident_consts.svh"
module serial_port_ident_and_irq_clear (
  input  wire logic        clk,
  input  wire logic        srst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        rx_timeout_event,
  input  wire logic        rx_overrun_event,
  output logic             rx_timeout_flag,
  output logic             rx_overrun_flag,
  output logic             irq
);
  ////////////////////////////////////////////////////////////////////
  // bus phase: no wait states, answer registered so outputs come from flops
  ident_pkg::apb_phase_t phase_q;
  logic                  setup;
  logic                  wr_clear;
  logic                  wr_mask;
  logic                  rom_hit;
  logic [7:0]            rom_data;
  logic [1:0]            flags;
  logic [1:0]            mask_q;
  logic [1:0]            clr;
  logic [31:0]           rdata_d;
  logic                  known;
  logic                  access_done;

  assign setup = psel && !penable;
  // writes land only at the completing edge of the access phase
  assign access_done = psel && penable && (phase_q == ident_pkg::APB_ACCESS);

  always_ff @(posedge clk) begin
    if (srst) begin
      phase_q <= ident_pkg::APB_IDLE;
    end else begin
      case (phase_q)
        ident_pkg::APB_IDLE:   phase_q <= setup ? ident_pkg::APB_ACCESS : ident_pkg::APB_IDLE;
        ident_pkg::APB_ACCESS: phase_q <= ident_pkg::APB_IDLE;
        default:               phase_q <= ident_pkg::APB_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////
  // register decode; writes take effect at the completing edge
  ident_rom u_rom (
    .addr (paddr),
    .hit  (rom_hit),
    .data (rom_data)
  );

  assign wr_clear = access_done && pwrite && (paddr == `OFS_IRQ_CLEAR);
  assign wr_mask  = access_done && pwrite && (paddr == `OFS_IRQ_MASK);
  assign clr      = wr_clear ? pwdata[1:0] : 2'h0;

  always_comb begin
    known   = 1'b1;
    rdata_d = 32'h0000_0000;
    if (rom_hit) begin
      rdata_d = {24'h00_0000, rom_data};
    end else if (paddr == `OFS_IRQ_STATUS) begin
      rdata_d = {30'h0000_0000, flags};
    end else if (paddr == `OFS_IRQ_MASK) begin
      rdata_d = {30'h0000_0000, mask_q};
    end else if (paddr == `OFS_IRQ_CLEAR) begin
      rdata_d = 32'h0000_0000; // write-only, reads zero
    end else begin
      known = 1'b0;
    end
  end

  // identity writes fall through: nothing stores them
  always_ff @(posedge clk) begin
    if (srst) begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else begin
      pready  <= setup;
      pslverr <= setup && !known;
      if (setup && !pwrite) begin
        prdata <= rdata_d;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      mask_q <= `RST_MASK;
    end else if (wr_mask) begin
      mask_q <= pwdata[1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // interrupt flags, one sticky cell each
  sticky_flag u_overrun (
    .clk         (clk),
    .srst        (srst),
    .set_pulse   (rx_overrun_event),
    .clear_pulse (clr[`BIT_RX_OVERRUN]),
    .flag_q      (flags[`BIT_RX_OVERRUN])
  );

  sticky_flag u_timeout (
    .clk         (clk),
    .srst        (srst),
    .set_pulse   (rx_timeout_event),
    .clear_pulse (clr[`BIT_RX_TIMEOUT]),
    .flag_q      (flags[`BIT_RX_TIMEOUT])
  );

  assign rx_overrun_flag = flags[`BIT_RX_OVERRUN];
  assign rx_timeout_flag = flags[`BIT_RX_TIMEOUT];

  // irq lags flags by one cycle so it comes from a flop
  always_ff @(posedge clk) begin
    if (srst) begin
      irq <= 1'b0;
    end else begin
      irq <= |(flags & mask_q);
    end
  end
endmodule
`default_nettype wire

// File: design/sticky_flag.sv
`default_nettype none
module sticky_flag (
  input  wire logic clk,
  input  wire logic srst,
  input  wire logic set_pulse,
  input  wire logic clear_pulse,
  output logic      flag_q
);
  // set wins over a clear in the same cycle so no event is lost
  always_ff @(posedge clk) begin
    if (srst) begin
      flag_q <= 1'b0;
    end else if (set_pulse) begin
      flag_q <= 1'b1;
    end else if (clear_pulse) begin
      flag_q <= 1'b0;
    end
  end
endmodule
`default_nettype wire
